// File: rtl/rtc_irq_pkg.sv
// Constants, field layout and timing counts of the alarm and periodic interrupt block
// Function
// - An enabled alarm pulls its interrupt pin low when current time equals alarm time.
// - Weekly alarm drives pin B only; daily alarm shares pin A with the periodic generator.
// - Weekly alarm compares day, hour, minute; daily alarm compares hour and minute.
// - Control register E: weekly enable D7, daily enable D6, periodic select D2..D0.
// - Status register F: periodic flag D2, weekly flag D1, daily flag D0.
// - Periodic select zero disables the generator and releases its output; it is default.
// - With enables and select cleared at power-on both pins are released high.
// - Several sources on one pin give a wired OR of their active-low outputs.
// - Writing 1 to an alarm enable arms that comparator, writing 0 disarms it.
// - Alarm flag reads its state; writing 1 does nothing, writing 0 clears and releases.
// - Clearing an alarm flag keeps its enable, so the next match asserts again.
// - Codes 010 and 011 give 2 Hz and 1 Hz half-duty pulses, second-aligned; the flag is set but the pulse ignores it.
// - In level mode the falling edge meets the seconds increment; code 100 fires each second.
// - Codes 101, 110, 111 fire at each new minute, hour and month start.
// - In level mode the output stays low until the host writes 0 to the periodic flag.
// - With adjustment active, every 20 s low time or interval shifts by at most 3.784 ms.
// - Reference output follows 32.768 kHz while its control pin is high, else held low.
// - Oscillation halt clears alarm enables, periodic select and all three flags.
package rtc_irq_pkg;

  localparam logic [3:0] ADDR_CTRL       = 4'he;
  localparam logic [3:0] ADDR_FLAG       = 4'hf;

  localparam int         WEEKLY_EN_BIT   = 7;
  localparam int         DAILY_EN_BIT    = 6;
  localparam int         SEL_LSB         = 0;
  localparam int         SEL_MSB         = 2;
  localparam int         PER_FLAG_BIT    = 2;
  localparam int         WEEKLY_FLAG_BIT = 1;
  localparam int         DAILY_FLAG_BIT  = 0;
  localparam int         PIN_A_BIT       = 4;
  localparam int         PIN_B_BIT       = 5;

  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] FLAG_RESET      = 8'h00;

  localparam logic [2:0] SEL_OFF         = 3'h0;
  localparam logic [2:0] SEL_FIXED_LOW   = 3'h1;
  localparam logic [2:0] SEL_PULSE_2HZ   = 3'h2;
  localparam logic [2:0] SEL_PULSE_1HZ   = 3'h3;
  localparam logic [2:0] SEL_LEVEL_SEC   = 3'h4;
  localparam logic [2:0] SEL_LEVEL_MIN   = 3'h5;
  localparam logic [2:0] SEL_LEVEL_HOUR  = 3'h6;
  localparam logic [2:0] SEL_LEVEL_MONTH = 3'h7;

  localparam longint     CLK_HZ          = 20_000_000;
  localparam longint     HALF_SEC_MS     = 500;
  localparam longint     QUARTER_SEC_MS  = 250;
  localparam longint     ADJ_MAX_US      = 3784;
  localparam int         ADJ_PERIOD_S    = 20;

  localparam longint     HALF_SEC_CYC    = HALF_SEC_MS * CLK_HZ / 1000;
  localparam longint     QUARTER_SEC_CYC = QUARTER_SEC_MS * CLK_HZ / 1000;
  localparam longint     ADJ_MAX_CYC     = ADJ_MAX_US * CLK_HZ / 1_000_000;

endpackage : rtc_irq_pkg

// File: rtl/time_cmp_if.sv
// Current time bundle passed from the top module to its alarm comparators
`timescale 1ns/100ps
`default_nettype none
interface time_cmp_if;
  logic [2:0] dow;
  logic [5:0] hour;
  logic [6:0] minute;
  modport src (output dow, hour, minute);
  modport cmp (input dow, hour, minute);
endinterface : time_cmp_if
`default_nettype wire

// File: rtl/alarm_match.sv
// One alarm comparator: one-cycle hit on the first cycle of a time match
`timescale 1ns/100ps
`default_nettype none
module alarm_match #(
  parameter bit WITH_DOW = 1'b1
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Current time
  time_cmp_if.cmp         now,
  // Alarm setting
  input  wire logic       enable,
  input  wire logic [6:0] dow_mask,
  input  wire logic [5:0] alarm_hour,
  input  wire logic [6:0] alarm_min,
  // Result
  output logic            hit
);

  typedef struct packed {
    logic prev;
    logic hit;
  } match_state_t;

  match_state_t st_q;
  match_state_t st_d;
  logic         same;

  always_comb begin
    same = (now.hour == alarm_hour) && (now.minute == alarm_min);
    if (WITH_DOW) begin
      // Day code 7 has no mask bit; it never matches instead of reading past the mask
      same = same && (now.dow != 3'h7) && dow_mask[now.dow];
    end
    st_d      = st_q;
    st_d.prev = same;
    // Only the start of a match counts, so a cleared flag is not re-set in that minute
    st_d.hit  = enable && same && !st_q.prev;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign hit = st_q.hit;

endmodule : alarm_match
`default_nettype wire

// File: rtl/rtc_alarm_periodic_irq.sv
// Alarm, periodic interrupt and reference clock output logic of the real-time clock
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_periodic_irq #(
  parameter longint HALF_CYC    = rtc_irq_pkg::HALF_SEC_CYC,
  parameter longint QUARTER_CYC = rtc_irq_pkg::QUARTER_SEC_CYC,
  parameter longint ADJ_MAX     = rtc_irq_pkg::ADJ_MAX_CYC
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Time counters
  input  wire logic       sec_tick,
  input  wire logic [6:0] cur_sec,
  input  wire logic [6:0] cur_min,
  input  wire logic [5:0] cur_hour,
  input  wire logic [2:0] cur_dow,
  input  wire logic [5:0] cur_day,
  // Alarm settings
  input  wire logic [6:0] alarm_w_dow_mask,
  input  wire logic [5:0] alarm_w_hour,
  input  wire logic [6:0] alarm_w_min,
  input  wire logic [5:0] alarm_d_hour,
  input  wire logic [6:0] alarm_d_min,
  // Oscillation halt and adjustment
  input  wire logic       osc_halt_flag,
  input  wire logic       adj_active,
  input  wire logic       adj_lengthen,
  input  wire logic [16:0] adj_cyc,
  // Reference clock pins
  input  wire logic       osc_clk_in,
  input  wire logic       ref_clock_out_ctrl,
  output logic            ref_clock_out,
  // Interrupt pin A
  input  wire logic       irq_in_a_n,
  output logic            irq_out_a_n,
  output logic            irq_oe_a_n,
  // Interrupt pin B
  input  wire logic       irq_in_b_n,
  output logic            irq_out_b_n,
  output logic            irq_oe_b_n
);

  localparam int PH_W = $clog2(HALF_CYC * 2 + ADJ_MAX + 2);
  localparam logic [PH_W-1:0] PH_MAX  = '1;
  localparam logic [PH_W-1:0] HALF_P  = PH_W'(HALF_CYC);
  localparam logic [PH_W-1:0] QUART_P = PH_W'(QUARTER_CYC);
  localparam logic [16:0]     ADJ_LIM = 17'(ADJ_MAX);
  localparam logic [4:0]      ADJ_WRAP = 5'(rtc_irq_pkg::ADJ_PERIOD_S - 1);

  if (QUARTER_CYC < 1 || HALF_CYC < 2 * QUARTER_CYC || ADJ_MAX >= QUARTER_CYC
      || ADJ_MAX > 131071) begin : g_bad_timing
    $error("rtc_alarm_periodic_irq: timing parameters out of range");
  end

  typedef struct packed {
    logic [7:0]      ctrl;
    logic [7:0]      flag;
    logic [7:0]      rdata;
    logic [PH_W-1:0] phase;
    logic [4:0]      adj_sec;
    logic            adj_now;
    logic [16:0]     adj_amt;
    logic            adj_long;
    logic            pulse_low;
    logic            osc_s1;
    logic            osc_s2;
    logic            ctl_s1;
    logic            ctl_s2;
    logic            pa_s1;
    logic            pa_s2;
    logic            pb_s1;
    logic            pb_s2;
    logic            ref_out;
    logic            drive_a;
    logic            drive_b;
  } irq_state_t;

  irq_state_t st_q;
  irq_state_t st_d;

  logic       weekly_hit;
  logic       daily_hit;
  logic [2:0] sel;
  logic       level_event;
  logic [PH_W-1:0] low_len;

  time_cmp_if now_bus ();

  assign now_bus.dow    = cur_dow;
  assign now_bus.hour   = cur_hour;
  assign now_bus.minute = cur_min;

  alarm_match #(
    .WITH_DOW (1'b1)
  ) u_weekly (
    .mclk       (mclk),
    .nrst       (nrst),
    .now        (now_bus),
    .enable     (st_q.ctrl[rtc_irq_pkg::WEEKLY_EN_BIT]),
    .dow_mask   (alarm_w_dow_mask),
    .alarm_hour (alarm_w_hour),
    .alarm_min  (alarm_w_min),
    .hit        (weekly_hit)
  );

  alarm_match #(
    .WITH_DOW (1'b0)
  ) u_daily (
    .mclk       (mclk),
    .nrst       (nrst),
    .now        (now_bus),
    .enable     (st_q.ctrl[rtc_irq_pkg::DAILY_EN_BIT]),
    .dow_mask   (7'h7f),
    .alarm_hour (alarm_d_hour),
    .alarm_min  (alarm_d_min),
    .hit        (daily_hit)
  );

  // Decodes an event from the counters as they stand in the tick cycle
  function automatic logic level_due(input logic [2:0] code, input logic [6:0] s,
                                     input logic [6:0] m, input logic [5:0] h,
                                     input logic [5:0] d);
    logic due;
    due = 1'b0;
    case (code)
      rtc_irq_pkg::SEL_LEVEL_SEC:   due = 1'b1;
      rtc_irq_pkg::SEL_LEVEL_MIN:   due = (s == 7'h00);
      rtc_irq_pkg::SEL_LEVEL_HOUR:  due = (s == 7'h00) && (m == 7'h00);
      rtc_irq_pkg::SEL_LEVEL_MONTH: due = (s == 7'h00) && (m == 7'h00)
                                          && (h == 6'h00) && (d == 6'h01);
      default:                      due = 1'b0;
    endcase
    return due;
  endfunction : level_due

  assign sel         = st_q.ctrl[rtc_irq_pkg::SEL_MSB:rtc_irq_pkg::SEL_LSB];
  assign level_event = sec_tick && level_due(sel, cur_sec, cur_min, cur_hour, cur_day);

  // Stretched or shortened first low phase inside the adjusting second
  always_comb begin
    low_len = (sel == rtc_irq_pkg::SEL_PULSE_2HZ) ? QUART_P : HALF_P;
    if (st_q.adj_now) begin
      if (st_q.adj_long) begin
        low_len = low_len + PH_W'(st_q.adj_amt);
      end else begin
        low_len = low_len - PH_W'(st_q.adj_amt);
      end
    end
  end

  always_comb begin
    st_d = st_q;

    // Pin and reference clock synchronisers
    st_d.osc_s1 = osc_clk_in;
    st_d.osc_s2 = st_q.osc_s1;
    st_d.ctl_s1 = ref_clock_out_ctrl;
    st_d.ctl_s2 = st_q.ctl_s1;
    st_d.pa_s1  = irq_in_a_n;
    st_d.pa_s2  = st_q.pa_s1;
    st_d.pb_s1  = irq_in_b_n;
    st_d.pb_s2  = st_q.pb_s1;
    // An open control pin reads low, so the output is held low then
    st_d.ref_out = st_q.osc_s2 && st_q.ctl_s2;

    // Phase since the last seconds increment, saturating until the next one
    if (sec_tick) begin
      st_d.phase = '0;
    end else if (st_q.phase != PH_MAX) begin
      st_d.phase = st_q.phase + PH_W'(1);
    end

    // Adjustment acts on one second out of every twenty
    if (sec_tick) begin
      st_d.adj_sec  = (st_q.adj_sec == ADJ_WRAP) ? 5'h00 : st_q.adj_sec + 5'h01;
      st_d.adj_now  = adj_active && (st_q.adj_sec == ADJ_WRAP);
      st_d.adj_amt  = (adj_cyc > ADJ_LIM) ? ADJ_LIM : adj_cyc;
      st_d.adj_long = adj_lengthen;
    end

    // Pulse waveform: low from the increment, high after the low phase
    case (sel)
      rtc_irq_pkg::SEL_PULSE_1HZ: begin
        st_d.pulse_low = sec_tick || (st_q.phase < low_len - PH_W'(1));
      end
      rtc_irq_pkg::SEL_PULSE_2HZ: begin
        st_d.pulse_low = sec_tick || (st_q.phase < low_len - PH_W'(1))
                         || ((st_q.phase >= HALF_P - PH_W'(1))
                             && (st_q.phase < HALF_P + QUART_P - PH_W'(1)));
      end
      default: begin
        st_d.pulse_low = 1'b0;
      end
    endcase
    if (st_q.phase == PH_MAX && !sec_tick) begin
      st_d.pulse_low = 1'b0;
    end

    // Register writes; flag bits only accept zero, and a new event beats the clear
    if (reg_wr && reg_addr == rtc_irq_pkg::ADDR_CTRL) begin
      st_d.ctrl = reg_wdata;
    end
    if (reg_wr && reg_addr == rtc_irq_pkg::ADDR_FLAG) begin
      st_d.flag[rtc_irq_pkg::PER_FLAG_BIT] = st_q.flag[rtc_irq_pkg::PER_FLAG_BIT]
                                             && reg_wdata[rtc_irq_pkg::PER_FLAG_BIT];
      st_d.flag[rtc_irq_pkg::WEEKLY_FLAG_BIT] = st_q.flag[rtc_irq_pkg::WEEKLY_FLAG_BIT]
                                        && reg_wdata[rtc_irq_pkg::WEEKLY_FLAG_BIT];
      st_d.flag[rtc_irq_pkg::DAILY_FLAG_BIT] = st_q.flag[rtc_irq_pkg::DAILY_FLAG_BIT]
                                        && reg_wdata[rtc_irq_pkg::DAILY_FLAG_BIT];
    end
    if (weekly_hit) begin
      st_d.flag[rtc_irq_pkg::WEEKLY_FLAG_BIT] = 1'b1;
    end
    if (daily_hit) begin
      st_d.flag[rtc_irq_pkg::DAILY_FLAG_BIT] = 1'b1;
    end
    // The flag follows each increment in pulse mode too, but the pulse ignores it
    if (level_event || (sec_tick && (sel == rtc_irq_pkg::SEL_PULSE_1HZ
                                     || sel == rtc_irq_pkg::SEL_PULSE_2HZ))) begin
      st_d.flag[rtc_irq_pkg::PER_FLAG_BIT] = 1'b1;
    end
    st_d.flag[7:3] = '0;

    // Oscillation halt wipes enables, select and flags while it stands
    if (osc_halt_flag) begin
      st_d.ctrl = rtc_irq_pkg::CTRL_RESET;
      st_d.flag = rtc_irq_pkg::FLAG_RESET;
    end

    // Read data are taken at the read strobe and held
    if (reg_rd) begin
      case (reg_addr)
        rtc_irq_pkg::ADDR_CTRL: st_d.rdata = st_q.ctrl;
        rtc_irq_pkg::ADDR_FLAG: begin
          st_d.rdata = st_q.flag;
          st_d.rdata[rtc_irq_pkg::PIN_A_BIT] = st_q.pa_s2;
          st_d.rdata[rtc_irq_pkg::PIN_B_BIT] = st_q.pb_s2;
        end
        default:                st_d.rdata = 8'h00;
      endcase
    end

    // Pin B: weekly alarm alone
    st_d.drive_b = st_d.flag[rtc_irq_pkg::WEEKLY_FLAG_BIT];
    // Pin A: wired OR of the daily alarm and the periodic generator
    case (st_d.ctrl[rtc_irq_pkg::SEL_MSB:rtc_irq_pkg::SEL_LSB])
      rtc_irq_pkg::SEL_OFF: begin
        st_d.drive_a = st_d.flag[rtc_irq_pkg::DAILY_FLAG_BIT];
      end
      rtc_irq_pkg::SEL_FIXED_LOW: begin
        st_d.drive_a = 1'b1;
      end
      rtc_irq_pkg::SEL_PULSE_2HZ, rtc_irq_pkg::SEL_PULSE_1HZ: begin
        st_d.drive_a = st_d.flag[rtc_irq_pkg::DAILY_FLAG_BIT] || st_d.pulse_low;
      end
      default: begin
        st_d.drive_a = st_d.flag[rtc_irq_pkg::DAILY_FLAG_BIT]
                       || st_d.flag[rtc_irq_pkg::PER_FLAG_BIT];
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata     = st_q.rdata;
  assign ref_clock_out = st_q.ref_out;
  // Open drain: output value is always low, the enable decides
  assign irq_out_a_n   = 1'b0;
  assign irq_out_b_n   = 1'b0;
  assign irq_oe_a_n    = !st_q.drive_a;
  assign irq_oe_b_n    = !st_q.drive_b;

endmodule : rtc_alarm_periodic_irq
`default_nettype wire

// File: dv/rtc_irq_sva.sv
// Port-level assertions for the alarm and periodic interrupt block
`timescale 1ns/100ps
`default_nettype none
module rtc_irq_sva (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Weekly alarm inputs
  input wire logic [6:0] cur_min,
  input wire logic [5:0] cur_hour,
  input wire logic [2:0] cur_dow,
  input wire logic [6:0] alarm_w_dow_mask,
  input wire logic [5:0] alarm_w_hour,
  input wire logic [6:0] alarm_w_min,
  // Halt and reference clock
  input wire logic       osc_halt_flag,
  input wire logic       osc_clk_in,
  input wire logic       ref_clock_out_ctrl,
  input wire logic       ref_clock_out,
  // Interrupt pins
  input wire logic       irq_out_a_n,
  input wire logic       irq_out_b_n,
  input wire logic       irq_oe_a_n,
  input wire logic       irq_oe_b_n
);
  logic [7:0] ctrl_q;
  logic       w_q;
  logic       w_qq;
  wire        w_match = (cur_dow != 3'h7) && alarm_w_dow_mask[cur_dow] &&
                        (cur_hour == alarm_w_hour) && (cur_min == alarm_w_min);
  // Shadow of the control register so pin relations can see the enables
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= 8'h00;
      w_q    <= 1'b0;
      w_qq   <= 1'b0;
    end else begin
      w_q  <= w_match;
      w_qq <= w_q;
      if (osc_halt_flag)
        ctrl_q <= 8'h00;
      else if (reg_wr && reg_addr == rtc_irq_pkg::ADDR_CTRL)
        ctrl_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_OPEN_DRAIN: assert property (!irq_out_a_n && !irq_out_b_n)
    else $error("interrupt pin data not held low");
  AST_B_CAUSE: assert property ($fell(irq_oe_b_n) |-> $past(w_match, 2) && $past(ctrl_q[7], 2))
    else $error("pin B fell without an armed weekly match");
  // Guarded by three quiet samples so a same-cycle set cannot win over the clear
  AST_B_CLEAR: assert property (reg_wr && reg_addr == rtc_irq_pkg::ADDR_FLAG && !reg_wdata[1] && !osc_halt_flag && !w_match && !w_q && !w_qq |-> ##[1:2] irq_oe_b_n)
    else $error("pin B not released by flag clear");
  AST_CODE1: assert property ((ctrl_q[2:0] == 3'h1) [*3] |-> !irq_oe_a_n)
    else $error("fixed low code does not hold pin A");
  AST_HALT: assert property (osc_halt_flag [*2] |=> irq_oe_a_n && irq_oe_b_n)
    else $error("pins not released after halt");
  AST_REF_LOW: assert property (!ref_clock_out_ctrl [*6] |-> !ref_clock_out)
    else $error("reference output not held low");
  AST_REF_ON: assert property (ref_clock_out_ctrl [*6] ##0 (osc_clk_in == $past(osc_clk_in, 5)) |-> ref_clock_out == osc_clk_in)
    else $error("reference output does not follow oscillator");
  AST_UNMAPPED: assert property (reg_rd && reg_addr < rtc_irq_pkg::ADDR_CTRL |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_FLAG_SPARE: assert property (reg_rd && reg_addr == rtc_irq_pkg::ADDR_FLAG |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[3])
    else $error("spare flag bits not zero");
  AST_CTRL_READ: assert property (reg_rd && !reg_wr && !osc_halt_flag && reg_addr == rtc_irq_pkg::ADDR_CTRL |=> reg_rdata == ctrl_q)
    else $error("control read differs from written value");
endmodule : rtc_irq_sva
bind rtc_alarm_periodic_irq rtc_irq_sva u_sva (.mclk, .nrst, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .cur_min, .cur_hour, .cur_dow, .alarm_w_dow_mask, .alarm_w_hour,
  .alarm_w_min, .osc_halt_flag, .osc_clk_in, .ref_clock_out_ctrl, .ref_clock_out,
  .irq_out_a_n, .irq_out_b_n, .irq_oe_a_n, .irq_oe_b_n);
`default_nettype wire

// File: dv/irq_host_model.sv
// Host side of the two interrupt lines: pull-ups and resolved levels
`timescale 1ns/100ps
`default_nettype none
module irq_host_model (
  // Device pin drivers
  input  wire logic irq_out_a_n,
  input  wire logic irq_oe_a_n,
  input  wire logic irq_out_b_n,
  input  wire logic irq_oe_b_n,
  // Line levels seen by the host
  output logic      pin_a,
  output logic      pin_b
);
  // A released line goes to the pull-up level, never the last driven value
  assign pin_a = irq_oe_a_n ? 1'b1 : irq_out_a_n;
  assign pin_b = irq_oe_b_n ? 1'b1 : irq_out_b_n;
endmodule : irq_host_model
`default_nettype wire

// File: dv/rtc_alarm_periodic_irq_tb_top.sv
// Self-checking bench for the alarm and periodic interrupt block
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_periodic_irq_tb_top;
  localparam longint HALF = 40;
  localparam longint QTR  = 20;
  localparam longint ADJ  = 4;
  localparam int     SEC  = int'(2 * HALF);
  logic mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sec_tick = 1'b0;
  logic osc_halt_flag = 1'b0, osc_clk_in = 1'b0, ref_clock_out_ctrl = 1'b0;
  logic adj_active = 1'b0, adj_lengthen = 1'b0;
  logic [16:0] adj_cyc = 17'h0_0000;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [6:0] cur_sec = 7'h01, cur_min = 7'h29, alarm_w_dow_mask = 7'h00;
  logic [6:0] alarm_w_min = 7'h30, alarm_d_min = 7'h30;
  logic [5:0] cur_hour = 6'h12, cur_day = 6'h02, alarm_w_hour = 6'h12, alarm_d_hour = 6'h12;
  logic [2:0] cur_dow = 3'h3;
  logic [7:0] reg_rdata;
  logic       ref_clock_out, irq_out_a_n, irq_oe_a_n, irq_out_b_n, irq_oe_b_n, pin_a, pin_b;
  int         failures = 0;
  int         n_tests  = 0;
  always #25 mclk = ~mclk;
  // Free-running 32.768 kHz oscillator, unrelated to mclk
  always #15258.8 osc_clk_in = ~osc_clk_in;
  rtc_alarm_periodic_irq #(.HALF_CYC(HALF), .QUARTER_CYC(QTR), .ADJ_MAX(ADJ)) DUT (
    .mclk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .sec_tick, .cur_sec,
    .cur_min, .cur_hour, .cur_dow, .cur_day, .alarm_w_dow_mask, .alarm_w_hour, .alarm_w_min,
    .alarm_d_hour, .alarm_d_min, .osc_halt_flag, .adj_active, .adj_lengthen,
    .adj_cyc, .osc_clk_in, .ref_clock_out_ctrl, .ref_clock_out,
    .irq_in_a_n(pin_a), .irq_out_a_n, .irq_oe_a_n, .irq_in_b_n(pin_b), .irq_out_b_n,
    .irq_oe_b_n);
  irq_host_model u_host (.irq_out_a_n, .irq_oe_a_n, .irq_out_b_n, .irq_oe_b_n, .pin_a, .pin_b);
  task automatic print_verdict();
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
  endtask : rd_chk
  // Time counters already hold the new value in the tick cycle
  task automatic tick(input logic [6:0] s, input logic [6:0] m, input logic [5:0] h,
                      input logic [5:0] d);
    @(posedge mclk);
    {cur_sec, cur_min, cur_hour, cur_day} <= {s, m, h, d};
    sec_tick <= 1'b1;
    @(posedge mclk);
    sec_tick <= 1'b0;
  endtask : tick
  task automatic wait_on(input int s, input logic lvl, input int n);
    int   i;
    logic v;
    for (i = 0; i < n; i++) begin
      cyc(1);
      v = (s == 0) ? pin_a : (s == 1) ? pin_b : ref_clock_out;
      if (v === lvl)
        break;
    end
    if (i == n) begin
      failures++;
      print_verdict();
    end
  endtask : wait_on
  task automatic low_run(input logic [7:0] exp, input string what);
    int n;
    n = 0;
    // Called at the edge that takes the increment, which is already the first low cycle
    #1;
    while (pin_a === 1'b0 && n < 200) begin
      n++;
      cyc(1);
    end
    check(what, 8'(n), exp);
  endtask : low_run
  task automatic min_set(input logic [6:0] m);
    @(posedge mclk);
    cur_min <= m;
  endtask : min_set
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rd_chk(rtc_irq_pkg::ADDR_CTRL, rtc_irq_pkg::CTRL_RESET, "ctrl reset");
    rd_chk(rtc_irq_pkg::ADDR_FLAG, 8'h30, "flag reset");
    wr(4'h3, 8'hff);
    rd_chk(4'h3, 8'h00, "unmapped");
    wr(rtc_irq_pkg::ADDR_CTRL, 8'hf8);
    rd_chk(rtc_irq_pkg::ADDR_CTRL, 8'hf8, "ctrl storage");
    wr(rtc_irq_pkg::ADDR_CTRL, 8'h00);
    wr(rtc_irq_pkg::ADDR_CTRL, 8'h40);
    min_set(7'h30);
    wait_on(0, 1'b0, 8);
    cyc(4);
    check("pin b daily", {7'h00, pin_b}, 8'h01);
    wr(rtc_irq_pkg::ADDR_FLAG, 8'h07);
    rd_chk(rtc_irq_pkg::ADDR_FLAG, 8'h21, "daily flag");
    min_set(7'h31);
    cyc(4);
    wr(rtc_irq_pkg::ADDR_FLAG, 8'h00);
    cyc(2);
    check("pin a cleared", {7'h00, pin_a}, 8'h01);
    rd_chk(rtc_irq_pkg::ADDR_CTRL, 8'h40, "enable kept");
    min_set(7'h30);
    wait_on(0, 1'b0, 8);
    wr(rtc_irq_pkg::ADDR_CTRL, 8'h44);
    tick(7'h01, 7'h30, 6'h12, 6'h02);
    cyc(3);
    rd_chk(rtc_irq_pkg::ADDR_FLAG, 8'h25, "shared flags");
    wr(rtc_irq_pkg::ADDR_FLAG, 8'h01);
    cyc(3);
    rd_chk(rtc_irq_pkg::ADDR_FLAG, 8'h21, "wired or");
    min_set(7'h31);
    cyc(4);
    wr(rtc_irq_pkg::ADDR_FLAG, 8'h00);
    cyc(2);
    check("pin a released", {7'h00, pin_a}, 8'h01);
    wr(rtc_irq_pkg::ADDR_CTRL, 8'h00);
    alarm_w_dow_mask <= 7'h01;
    wr(rtc_irq_pkg::ADDR_CTRL, 8'h80);
    min_set(7'h30);
    cyc(6);
    check("wrong day", {6'h00, pin_b, pin_a}, 8'h03);
    @(posedge mclk);
    alarm_w_dow_mask <= 7'h08;
    wait_on(1, 1'b0, 8);
    cyc(4);
    rd_chk(rtc_irq_pkg::ADDR_FLAG, 8'h12, "weekly flag");
    min_set(7'h31);
    cyc(4);
    wr(rtc_irq_pkg::ADDR_FLAG, 8'h00);
    cyc(2);
    check("pin b cleared", {7'h00, pin_b}, 8'h01);
    for (int c = 4; c < 8; c++) begin
      wr(rtc_irq_pkg::ADDR_CTRL, {5'h00, 3'(c)});
      tick(7'h01, 7'h01, 6'h01, 6'h02);
      cyc(3);
      check("off boundary", {7'h00, pin_a}, (c == 4) ? 8'h00 : 8'h01);
      wr(rtc_irq_pkg::ADDR_FLAG, 8'h00);
      tick(7'h00, 7'h00, 6'h00, 6'h01);
      cyc(6);
      rd_chk(rtc_irq_pkg::ADDR_FLAG, 8'h24, "level held");
      wr(rtc_irq_pkg::ADDR_FLAG, 8'h00);
      cyc(2);
      check("level cleared", {7'h00, pin_a}, 8'h01);
    end
    // Pulse mode entered early in a second would show that second's low phase
    cyc(SEC);
    wr(rtc_irq_pkg::ADDR_CTRL, {5'h00, rtc_irq_pkg::SEL_PULSE_1HZ});
    tick(7'h01, 7'h01, 6'h01, 6'h02);
    low_run(8'(HALF), "1 Hz low");
    // The pin level must pass the synchroniser before the flag read shows it high
    cyc(SEC);
    rd_chk(rtc_irq_pkg::ADDR_FLAG, 8'h34, "pulse ignores flag");
    wr(rtc_irq_pkg::ADDR_CTRL, {5'h00, rtc_irq_pkg::SEL_PULSE_2HZ});
    tick(7'h02, 7'h01, 6'h01, 6'h02);
    low_run(8'(QTR), "2 Hz low");
    wait_on(0, 1'b0, 30);
    // Increments 12 to 19 since reset, then the twentieth carries a clamped stretch
    wr(rtc_irq_pkg::ADDR_CTRL, {5'h00, rtc_irq_pkg::SEL_PULSE_1HZ});
    repeat (8) tick(7'h04, 7'h01, 6'h01, 6'h02);
    cyc(SEC);
    adj_active   <= 1'b1;
    adj_lengthen <= 1'b1;
    adj_cyc      <= 17'h0_0009;
    tick(7'h05, 7'h01, 6'h01, 6'h02);
    low_run(8'(HALF + ADJ), "adjusted low");
    adj_active   <= 1'b0;
    wr(rtc_irq_pkg::ADDR_CTRL, {5'h00, rtc_irq_pkg::SEL_FIXED_LOW});
    wr(rtc_irq_pkg::ADDR_FLAG, 8'h00);
    cyc(3);
    check("fixed low", {7'h00, pin_a}, 8'h00);
    wr(rtc_irq_pkg::ADDR_CTRL, 8'h00);
    cyc(3);
    check("off", {7'h00, pin_a}, 8'h01);
    @(posedge mclk);
    ref_clock_out_ctrl <= 1'b1;
    wait_on(2, 1'b1, 1400);
    wait_on(2, 1'b0, 1400);
    ref_clock_out_ctrl <= 1'b0;
    cyc(6);
    check("ref gated", {7'h00, ref_clock_out}, 8'h00);
    wr(rtc_irq_pkg::ADDR_CTRL, 8'hc4);
    tick(7'h03, 7'h01, 6'h01, 6'h02);
    @(posedge mclk);
    osc_halt_flag <= 1'b1;
    cyc(2);
    osc_halt_flag <= 1'b0;
    cyc(3);
    rd_chk(rtc_irq_pkg::ADDR_CTRL, 8'h00, "halt ctrl");
    rd_chk(rtc_irq_pkg::ADDR_FLAG, 8'h30, "halt flags");
    print_verdict();
  end
endmodule : rtc_alarm_periodic_irq_tb_top
`default_nettype wire
